// File: hdl/adcsp_port.sv
// Contract
// - A gated serial clock with pauses keeps all shift state between bursts.
// - The port shifts only while chip select is held low.
// - With chip select tied low the port runs on clock, input and output alone.
// - The shared output pin goes low when a conversion has completed.
// - An unread result lets the pin return high before the next update.
// - Output bits change on the falling clock edge and are sampled on the rising one.
// - The output shift register loads from any readable register.
// - Input words land in the mode, configuration or IO register chosen by the communications word; other targets drop them.
// - The two spare analog pins may act as general purpose outputs.
// - The pin returns high once the result has been read.
// - Continuous read presents each word once; other modes allow re-reading.
// - The output is released once chip select goes high.
// - Every access except further continuous-read words starts with a communications write choosing the next register.
`timescale 1ns/1ps
module adcsp_port
	import adcsp_pkg::*;
#(
	parameter logic [7:0] ID_CODE = ID_DEFAULT
) (
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	input  wire logic              sclk_i,
	input  wire logic              cs_n_i,
	input  wire logic              din_i,
	input  wire logic              conv_done_i,
	input  wire logic [W_MAX-1:0]  conv_data_i,
	input  wire logic              conv_upd_i,
	output logic                   dout_o,
	output logic                   dout_oe_n_o,
	output logic                   rdy_n_o,
	output logic [15:0]            mode_o,
	output logic [15:0]            conf_o,
	output logic                   aux_out_a_o,
	output logic                   aux_out_b_o,
	output logic                   aux_en_o,
	output logic                   low_side_switch_o
);

	// Frame state, cleared when chip select rises
	typedef struct packed {
		adcsp_phase_e phase;
		logic [4:0]   cnt;
		logic [4:0]   len;
		logic [2:0]   rs;
		logic         cread;
		logic         rd_start;
		logic [23:0]  sr;
	} adcsp_frame_s;

	// Link registers, kept across frames
	typedef struct packed {
		logic [15:0] mode;
		logic [15:0] conf;
		logic [7:0]  io;
		logic [23:0] data;
		logic        fresh;
		logic        pub_seen;
		logic        wr_tog;
		logic        rd_tog;
	} adcsp_lreg_s;

	typedef struct packed {
		logic [23:0] out;
		logic        dbit;
		logic        drv;
	} adcsp_neg_s;

	typedef struct packed {
		logic        rdy_n;
		logic [23:0] hold;
		logic [23:0] nxt;
		logic        pend;
		logic        pub_tog;
		logic        wr_seen;
		logic        rd_seen;
		logic [15:0] mode;
		logic [15:0] conf;
		logic [7:0]  io;
	} adcsp_sys_s;

	localparam adcsp_frame_s FRAME_RST = '{PH_CMD, 5'h00, LEN_STAT, RS_COMM,
		1'b0, 1'b0, 24'h000000};
	localparam adcsp_lreg_s  LREG_RST  = '{MODE_RST, CONF_RST, IO_RST, DATA_RST,
		1'b0, 1'b0, 1'b0, 1'b0};
	localparam adcsp_sys_s   SYS_RST   = '{1'b1, DATA_RST, DATA_RST, 1'b0, 1'b0, 1'b0,
		1'b0, MODE_RST, CONF_RST, IO_RST};

	adcsp_frame_s lf;
	adcsp_frame_s next_lf;
	adcsp_lreg_s  lr;
	adcsp_lreg_s  next_lr;
	adcsp_neg_s   n;
	adcsp_neg_s   next_n;
	adcsp_sys_s   s;
	adcsp_sys_s   next_s;

	logic        frame_clr;
	logic        pub_l;
	logic        rdy_l;
	logic        wr_s;
	logic        rd_s;
	logic        ack_s;
	logic [23:0] sr_in;
	logic [23:0] load_word;
	logic [23:0] rd_val;

	// Frame logic is held clear while deselected
	assign frame_clr = rst_i | cs_n_i;

	adcsp_sync #(.STAGES(SYNC_STAGES)) u_pub_sync (
		.clk_i (sclk_i),
		.rst_i (rst_i),
		.ce_i  (1'b1),
		.d_i   (s.pub_tog),
		.q_o   (pub_l)
	);

	adcsp_sync #(.STAGES(SYNC_STAGES)) u_rdy_sync (
		.clk_i (sclk_i),
		.rst_i (rst_i),
		.ce_i  (1'b1),
		.d_i   (s.rdy_n),
		.q_o   (rdy_l)
	);

	adcsp_sync #(.STAGES(SYNC_STAGES)) u_wr_sync (
		.clk_i (clk_sys_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.d_i   (lr.wr_tog),
		.q_o   (wr_s)
	);

	adcsp_sync #(.STAGES(SYNC_STAGES)) u_rd_sync (
		.clk_i (clk_sys_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.d_i   (lr.rd_tog),
		.q_o   (rd_s)
	);

	adcsp_sync #(.STAGES(SYNC_STAGES)) u_ack_sync (
		.clk_i (clk_sys_i),
		.rst_i (rst_i),
		.ce_i  (ce_i),
		.d_i   (lr.pub_seen),
		.q_o   (ack_s)
	);

	// Readback source for the selected register
	always_comb begin
		case (lf.rs)
			RS_MODE: rd_val = {8'h00, lr.mode};
			RS_CONF: rd_val = {8'h00, lr.conf};
			RS_DATA: rd_val = (lf.cread && !lr.fresh) ? 24'hffffff : lr.data;
			RS_ID:   rd_val = {16'h0000, ID_CODE};
			RS_IO:   rd_val = {16'h0000, lr.io};
			default: rd_val = {16'h0000, rdy_l, 4'h0, lr.conf[2:0]};
		endcase
		// Left align so the top bit leaves first
		load_word = rd_val << (5'(W_MAX) - lf.len);
	end

	assign sr_in = {lf.sr[22:0], din_i};

	// Rising edge: sample input, count bits, route words
	always_comb begin
		next_lf = lf;
		next_lr = lr;
		case (lf.phase)
			PH_CMD: begin
				next_lf.sr  = sr_in;
				next_lf.cnt = lf.cnt + 5'h01;
				if (lf.cnt == 5'(CMD_LEN - 1)) begin
					next_lf.cnt   = 5'h00;
					next_lf.rs    = sr_in[CMD_RS_HI:CMD_RS_LO];
					next_lf.len   = adcsp_len(sr_in[CMD_RS_HI:CMD_RS_LO]);
					next_lf.cread = sr_in[CMD_CREAD_BIT] &&
						(sr_in[CMD_RS_HI:CMD_RS_LO] == RS_DATA);
					if (sr_in[CMD_WEN_BIT]) begin
						// Idle ones between accesses are ignored
						next_lf.phase = PH_CMD;
					end else if (sr_in[CMD_RW_BIT]) begin
						next_lf.phase    = PH_RD;
						next_lf.rd_start = 1'b1;
					end else if (sr_in[CMD_RS_HI:CMD_RS_LO] != RS_COMM) begin
						next_lf.phase = PH_WR;
					end
				end
			end
			PH_WR: begin
				next_lf.sr  = sr_in;
				next_lf.cnt = lf.cnt + 5'h01;
				if (lf.cnt == lf.len - 5'h01) begin
					next_lf.cnt   = 5'h00;
					next_lf.phase = PH_CMD;
					next_lr.wr_tog = ~lr.wr_tog;
					case (lf.rs)
						RS_MODE: next_lr.mode = sr_in[15:0];
						RS_CONF: next_lr.conf = sr_in[15:0];
						RS_IO:   next_lr.io   = sr_in[7:0];
						default: next_lr.wr_tog = lr.wr_tog;
					endcase
				end
			end
			PH_RD: begin
				next_lf.rd_start = 1'b0;
				next_lf.cnt      = lf.cnt + 5'h01;
				if (lf.cnt == lf.len - 5'h01) begin
					next_lf.cnt = 5'h00;
					if (lf.rs == RS_DATA) begin
						next_lr.rd_tog = ~lr.rd_tog;
						next_lr.fresh  = 1'b0;
					end
					if (lf.cread) begin
						next_lf.rd_start = 1'b1;
					end else begin
						next_lf.phase = PH_CMD;
					end
				end
			end
			default: next_lf = FRAME_RST;
		endcase
		if (pub_l != lr.pub_seen) begin // New word beats a read clear
			next_lr.pub_seen = pub_l;
			next_lr.data     = s.hold;
			next_lr.fresh    = 1'b1;
		end
	end

	// Shift state only moves on clock edges, so pauses are harmless
	always_ff @(posedge sclk_i or posedge frame_clr) begin
		if (frame_clr) begin
			lf <= FRAME_RST;
		end else begin
			lf <= next_lf;
		end
	end

	always_ff @(posedge sclk_i or posedge rst_i) begin
		if (rst_i) begin
			lr <= LREG_RST;
		end else begin
			lr <= next_lr;
		end
	end

	// Falling edge: present the next output bit
	always_comb begin
		next_n = n;
		if (lf.rd_start) begin
			next_n.out  = {load_word[22:0], 1'b0};
			next_n.dbit = load_word[23];
			next_n.drv  = 1'b1;
		end else if (lf.phase == PH_RD) begin
			next_n.out  = {n.out[22:0], 1'b0};
			next_n.dbit = n.out[23];
			next_n.drv  = 1'b1;
		end else begin
			next_n.drv = 1'b0;
		end
	end

	always_ff @(negedge sclk_i or posedge frame_clr) begin
		if (frame_clr) begin
			n <= '0;
		end else begin
			n <= next_n;
		end
	end

	// System side: ready flag and published registers
	always_comb begin
		next_s = s;
		if (ce_i) begin
			if (rd_s != s.rd_seen) begin
				next_s.rd_seen = rd_s;
				next_s.rdy_n   = 1'b1;
			end
			if (conv_upd_i) begin
				next_s.rdy_n = 1'b1;
			end
			// A new result wins over a read in the same cycle
			if (conv_done_i) begin
				next_s.rdy_n = 1'b0;
				// Park the word while the link still owes a take
				if (ack_s == s.pub_tog) begin
					next_s.hold    = conv_data_i;
					next_s.pub_tog = ~s.pub_tog;
					next_s.pend    = 1'b0;
				end else begin
					next_s.nxt  = conv_data_i;
					next_s.pend = 1'b1;
				end
			end else if (s.pend && ack_s == s.pub_tog) begin
				next_s.hold    = s.nxt;
				next_s.pub_tog = ~s.pub_tog;
				next_s.pend    = 1'b0;
			end
			// Link copy is stable once its toggle arrives
			if (wr_s != s.wr_seen) begin
				next_s.wr_seen = wr_s;
				next_s.mode    = lr.mode;
				next_s.conf    = lr.conf;
				next_s.io      = lr.io;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			s <= SYS_RST;
		end else begin
			s <= next_s;
		end
	end

	// Pin mux: data while reading, ready otherwise
	assign dout_o            = n.drv ? n.dbit : s.rdy_n;
	assign dout_oe_n_o       = cs_n_i;
	assign rdy_n_o           = s.rdy_n;
	assign mode_o            = s.mode;
	assign conf_o            = s.conf;
	assign aux_out_a_o       = s.io[IO_A_BIT];
	assign aux_out_b_o       = s.io[IO_B_BIT];
	assign aux_en_o          = s.io[IO_EN_BIT];
	assign low_side_switch_o = s.io[IO_PSW_BIT];

endmodule

// File: include/adcsp_pkg.sv
package adcsp_pkg;

	// Serial word framing
	localparam int unsigned  CMD_LEN       = 8;
	localparam int unsigned  W_MAX         = 24;
	localparam int unsigned  CMD_WEN_BIT   = 7;
	localparam int unsigned  CMD_RW_BIT    = 6;
	localparam int unsigned  CMD_RS_HI     = 5;
	localparam int unsigned  CMD_RS_LO     = 3;
	localparam int unsigned  CMD_CREAD_BIT = 2;

	// Values of register_select_bits
	localparam logic [2:0]   RS_COMM = 3'h0;
	localparam logic [2:0]   RS_MODE = 3'h1;
	localparam logic [2:0]   RS_CONF = 3'h2;
	localparam logic [2:0]   RS_DATA = 3'h3;
	localparam logic [2:0]   RS_ID   = 3'h4;
	localparam logic [2:0]   RS_IO   = 3'h5;

	// Word lengths per register
	localparam logic [4:0]   LEN_STAT = 5'h08;
	localparam logic [4:0]   LEN_MODE = 5'h10;
	localparam logic [4:0]   LEN_CONF = 5'h10;
	localparam logic [4:0]   LEN_DATA = 5'h18;
	localparam logic [4:0]   LEN_ID   = 5'h08;
	localparam logic [4:0]   LEN_IO   = 5'h08;

	// Reset values
	localparam logic [15:0]  MODE_RST = 16'h000a;
	localparam logic [15:0]  CONF_RST = 16'h0710;
	localparam logic [7:0]   IO_RST   = 8'h00;
	localparam logic [23:0]  DATA_RST = 24'h000000;
	// Arbitrary identity value
	localparam logic [7:0]   ID_DEFAULT = 8'h5a;

	// Field positions and synchronizer depth
	localparam int unsigned  ST_RDY_BIT  = 7;
	localparam int unsigned  IO_A_BIT    = 0;
	localparam int unsigned  IO_B_BIT    = 1;
	localparam int unsigned  IO_PSW_BIT  = 3;
	localparam int unsigned  IO_EN_BIT   = 4;
	localparam int unsigned  SYNC_STAGES = 3;

	typedef enum logic [2:0] {
		PH_CMD = 3'b001,
		PH_WR  = 3'b010,
		PH_RD  = 3'b100
	} adcsp_phase_e;

	function automatic logic [4:0] adcsp_len(input logic [2:0] rs);
		case (rs)
			RS_MODE: adcsp_len = LEN_MODE;
			RS_CONF: adcsp_len = LEN_CONF;
			RS_DATA: adcsp_len = LEN_DATA;
			RS_ID:   adcsp_len = LEN_ID;
			RS_IO:   adcsp_len = LEN_IO;
			default: adcsp_len = LEN_STAT;
		endcase
	endfunction

endpackage

// File: hdl/adcsp_sync.sv
`timescale 1ns/1ps
module adcsp_sync
	import adcsp_pkg::*;
#(
	parameter int unsigned STAGES = SYNC_STAGES
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	input  wire logic d_i,
	output logic      q_o
);

	typedef struct packed {
		logic [STAGES-1:0] sh;
	} adcsp_sync_s;

	adcsp_sync_s r;
	adcsp_sync_s next_r;

	// First stage feeds only the next stage
	always_comb begin
		next_r = r;
		if (ce_i) begin
			next_r.sh = {r.sh[STAGES-2:0], d_i};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign q_o = r.sh[STAGES-1];

endmodule

// File: dv/adcsp_port_assertions.sv
`timescale 1ns/1ps
module adcsp_chk (
	input wire logic        clk_sys_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	input wire logic        cs_n_i,
	input wire logic        conv_done_i,
	input wire logic        conv_upd_i,
	input wire logic        dout_o,
	input wire logic        dout_oe_n_o,
	input wire logic        rdy_n_o,
	input wire logic [15:0] mode_o,
	input wire logic [15:0] conf_o,
	input wire logic        aux_out_a_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// Long enough for a late register update to land
	sequence s_idle;
		cs_n_i [*7];
	endsequence
	a_oe_follows_cs: assert property (dout_oe_n_o == cs_n_i)
		else $error("enable not following select");
	a_rdy_on_done: assert property (ce_i && conv_done_i |=> !rdy_n_o)
		else $error("ready missing after conversion");
	a_rdy_fall_cause: assert property ($fell(rdy_n_o) |-> $past(conv_done_i) && $past(ce_i))
		else $error("ready fell without conversion");
	a_upd_rdy_high: assert property (ce_i && conv_upd_i && !conv_done_i |-> ##[1:3] rdy_n_o)
		else $error("ready not cleared by update");
	a_cfg_stable_idle: assert property (s_idle |-> $stable(mode_o) && $stable(conf_o)
		&& $stable(aux_out_a_o))
		else $error("register changed outside a frame");
	a_rdy_low_holds: assert property (s_idle ##0 (!rdy_n_o && !conv_upd_i) |=> !rdy_n_o)
		else $error("ready cleared without read");
	a_pin_is_ready: assert property (s_idle |-> dout_o == rdy_n_o)
		else $error("pin not showing ready");
	a_ce_freeze: assert property (!ce_i |=> $stable(rdy_n_o) && $stable(mode_o))
		else $error("state moved with enable low");
endmodule
bind adcsp_port adcsp_chk chk (.clk_sys_i, .rst_i, .ce_i, .cs_n_i, .conv_done_i, .conv_upd_i,
	.dout_o, .dout_oe_n_o, .rdy_n_o, .mode_o, .conf_o, .aux_out_a_o);

// File: dv/adcsp_host.sv
`timescale 1ns/1ps
module adcsp_host (
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      din_o,
	input  wire logic dout_i
);
	initial begin
		sclk_o = 1'b1;
		cs_n_o = 1'b1;
		din_o = 1'b1;
	end
	// Clock idles high and stands still between frames
	task automatic shift(input logic [23:0] tx, input int n, input int gap,
		output logic [23:0] rx);
		rx = '0;
		cs_n_o = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			#15 sclk_o = 1'b0;
			din_o = tx[i];
			#15 sclk_o = 1'b1;
			rx = {rx[22:0], dout_i};
			if (gap != 0 && i % 8 == 0) #(gap);
		end
	endtask
	// Released data line toggles so no stale level is trusted
	task automatic release_bus();
		#15 cs_n_o = 1'b1;
		din_o = ~din_o;
		// Deselect long enough to end the frame
		#30;
	endtask
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import adcsp_pkg::*;
	logic             clk_sys_i = 1'b0;
	logic             rst_i = 1'b1;
	logic             ce_i = 1'b1;
	logic             conv_done_i = 1'b0;
	logic             conv_upd_i = 1'b0;
	logic [W_MAX-1:0] conv_data_i = '0;
	logic             sclk, cs_n, din, dout, oe_n, rdy_n, aux_a, aux_b, aux_en, lss;
	logic [15:0]      mode, conf, cf, mv;
	logic [23:0]      rx, val, word;
	logic [2:0]       rs;
	int               failures = 0;
	int               check_count = 0;
	always #25 clk_sys_i = ~clk_sys_i;
	adcsp_port dut (.clk_sys_i, .rst_i, .ce_i, .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
		.conv_done_i, .conv_data_i, .conv_upd_i, .dout_o(dout), .dout_oe_n_o(oe_n),
		.rdy_n_o(rdy_n), .mode_o(mode), .conf_o(conf), .aux_out_a_o(aux_a),
		.aux_out_b_o(aux_b), .aux_en_o(aux_en), .low_side_switch_o(lss));
	adcsp_host host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));
	function automatic logic [7:0] cmd(input int rd, input logic [2:0] r, input int cr);
		return {1'b0, rd[0], r, cr[0], 2'b00};
	endfunction
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic access(input logic [7:0] c, input int n, input logic [23:0] wd,
		input int gap, output logic [23:0] rd);
		host.shift({16'h0000, c}, 8, gap, rd);
		host.shift(wd, n, gap, rd);
		host.release_bus();
		#100;
	endtask
	task automatic conv(input logic [23:0] d, input logic upd);
		@(negedge clk_sys_i);
		conv_data_i = d;
		conv_done_i = !upd;
		conv_upd_i = upd;
		@(negedge clk_sys_i);
		conv_done_i = 1'b0;
		conv_upd_i = 1'b0;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#500us;
		failures++;
		conclude();
	end
	initial begin
		void'($urandom(95186));
		repeat (16) @(negedge clk_sys_i);
		rst_i = 1'b0;
		check("reset pins", {dout, rdy_n, aux_a, aux_b, aux_en, lss}, 6'h30);
		check("reset mode", mode, MODE_RST);
		check("reset conf", conf, CONF_RST);
		access(cmd(0, RS_ID, 0), 8, ~ID_DEFAULT, 0, rx);
		access(cmd(1, RS_ID, 0), 8, 0, 0, rx);
		check("id", rx[7:0], ID_DEFAULT);
		for (int k = 0; k < 4; k++) begin
			val = 24'($urandom);
			rs = k[0] ? RS_CONF : RS_MODE;
			if (k[0]) cf = val[15:0];
			else mv = val[15:0];
			access(cmd(0, rs, 0), 16, val, k * 45, rx);
			access(cmd(1, rs, 0), 16, 0, 0, rx);
			check("reg read", rx[15:0], val[15:0]);
			check("reg port", k[0] ? conf : mode, val[15:0]);
		end
		val = 24'($urandom);
		access(cmd(0, RS_IO, 0), 8, val, 0, rx);
		repeat (4) @(negedge clk_sys_i);
		check("aux", {aux_en, lss, aux_b, aux_a}, {val[4:3], val[1:0]});
		word = 24'($urandom);
		conv(word, 0);
		check("ready", rdy_n, 1'b0);
		check("ready pin", dout, 1'b0);
		access(cmd(1, RS_COMM, 0), 8, 0, 0, rx);
		check("status", rx[7:0], {5'h00, cf[2:0]});
		for (int k = 0; k < 2; k++) begin
			access(cmd(1, RS_DATA, 0), 24, 0, 0, rx);
			check("data", rx, word);
			repeat (6) @(negedge clk_sys_i);
			check("ready off", rdy_n, 1'b1);
		end
		conv(24'($urandom), 0);
		conv(0, 1);
		repeat (3) @(negedge clk_sys_i);
		check("update", rdy_n, 1'b1);
		ce_i = 1'b0;
		conv(0, 0);
		check("frozen", rdy_n, 1'b1);
		ce_i = 1'b1;
		word = 24'($urandom);
		conv(word, 0);
		access(cmd(1, RS_COMM, 0), 8, 0, 0, rx);
		host.shift({16'h0000, cmd(1, RS_DATA, 1)}, 8, 0, rx);
		host.shift(0, 24, 0, rx);
		check("stream", rx, word);
		host.shift(0, 24, 0, rx);
		check("stream again", rx, 24'hffffff);
		host.release_bus();
		host.shift({16'h0000, cmd(1, RS_MODE, 0)}, 8, 0, rx);
		host.shift(0, 5, 0, rx);
		host.release_bus();
		access(cmd(1, RS_MODE, 0), 16, 0, 0, rx);
		check("after abort", rx[15:0], mv);
		host.shift(24'h0000ff, 8, 0, rx);
		host.shift({16'h0000, cmd(1, RS_ID, 0)}, 8, 0, rx);
		host.shift(24'h000000, 8, 0, rx);
		check("idle ones", rx[7:0], ID_DEFAULT);
		host.release_bus();
		conclude();
	end
endmodule
